// ==== logic/absp_pkg.sv ====
// Package for the async and burst SRAM port: types, offsets, reset values.
package absp_pkg;

  // Register byte offsets on the Wishbone slave
  localparam logic [7:0] ABSP_OFS_CTRL = 8'h00;
  localparam logic [7:0] ABSP_OFS_ADDR = 8'h04;
  localparam logic [7:0] ABSP_OFS_STATUS = 8'h08;
  localparam logic [7:0] ABSP_OFS_DATA0 = 8'h10;
  localparam logic [7:0] ABSP_OFS_CFG0 = 8'h20;

  // Geometry of the memory side
  localparam int ABSP_SPACES = 4;
  localparam int ABSP_BEATS = 4;
  localparam int ABSP_ADDR_W = 20;
  localparam int ABSP_CNT_W = 6;

  // Status bit positions
  localparam int ABSP_ST_BUSY = 0;
  localparam int ABSP_ST_DONE = 1;

  // Per-space timing and mode word
  typedef struct packed {
    logic burst_mode;               // 1: burst SRAM space, 0: asynchronous
    logic [4:0] rsvd;               // Reads as zero
    logic [2:0] write_hold_count;   // Periods of select and data hold after write
    logic [5:0] write_strobe_count; // Periods of write strobe low
    logic [3:0] write_setup_count;  // Periods of select before write strobe
    logic [2:0] read_hold_count;    // Periods of select hold after read
    logic [5:0] read_strobe_count;  // Periods of read strobe low
    logic [3:0] read_setup_count;   // Periods of select before read strobe
  } absp_cfg_t;

  // Slowest legal timing after reset, safe for any memory
  localparam absp_cfg_t ABSP_CFG_RST = '{1'b0, 5'h00, 3'h7, 6'h3F, 4'hF, 3'h7, 6'h3F, 4'hF};

  // Command word; a write to it starts one access
  typedef struct packed {
    logic [23:0] rsvd;
    logic [3:0] byte_en;            // Active-high byte lanes
    logic decrement;                // Burst only: walk addresses downward
    logic write;                    // 1: write, 0: read
    logic [1:0] space;              // Chip space to use
  } absp_ctrl_t;

  localparam absp_ctrl_t ABSP_CTRL_RST = '{24'h000000, 4'hF, 1'b0, 1'b0, 2'h0};

  // Everything the port drives toward the memories
  typedef struct packed {
    logic [3:0] cs_n;               // chip_space_select, active low
    logic [3:0] be_n;               // byte_lane_enable, active low
    logic [19:0] addr;              // ext_address word lines
    logic rd_ads_n;                 // Read strobe or burst_addr_strobe
    logic oe_n;                     // async_output_enable or burst_output_enable
    logic we_n;                     // async_write_strobe or burst_write_enable
    logic [31:0] data;              // ext_data driven on writes
    logic data_oe;                  // High while the port drives ext_data
  } absp_pins_t;

  localparam absp_pins_t ABSP_PINS_IDLE = '{4'hF, 4'hF, 20'h00000, 1'b1, 1'b1, 1'b1,
                                            32'h00000000, 1'b0};

  // Memory cycle sequencer; Gray along idle-setup-strobe-hold
  typedef enum logic [2:0] {
    ABSP_IDLE = 3'b000,
    ABSP_SETUP = 3'b001,
    ABSP_STROBE = 3'b011,
    ABSP_HOLD = 3'b010,
    ABSP_BURST = 3'b110
  } absp_state_t;

endpackage : absp_pkg

// ==== logic/absp_port.sv ====
// Async and burst SRAM port: Wishbone registers, memory-clock sequencer, crossings.
//
// Design decisions made here: the placing of the registers and the Wishbone slave port.
`timescale 1ns/1ns

// Three-stage synchroniser; the output moves once stages two and three agree
module absp_sync3 #(
  parameter int W = 1
) (
  input wire logic clk_i,
  input wire logic [W-1:0] d_i,
  output logic [W-1:0] q_o
);
  logic [W-1:0] s1_q; // Metastable stage, read only by s2_q
  logic [W-1:0] s2_q;
  logic [W-1:0] s3_q;
  wire [W-1:0] agree_w = ~(s2_q ^ s3_q);

  // No reset here: a reset would itself need crossing
  always_ff @(posedge clk_i) begin
    s1_q <= d_i;
    s2_q <= s1_q;
    s3_q <= s2_q;
    q_o <= (agree_w & s2_q) | (~agree_w & q_o);
  end
endmodule : absp_sync3

module absp_port #(
  parameter int BURST_RD_LAT = 2 // Edges from address strobe to first read word
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic memclk_in_i,
  output logic memclk_out_o,
  input wire logic async_ready_in_i,
  output logic [3:0] chip_space_select_n_o,
  output logic [3:0] byte_lane_enable_n_o,
  output logic [absp_pkg::ABSP_ADDR_W-1:0] ext_address_o,
  output logic pin_rd_ads_n_o,
  output logic pin_oe_n_o,
  output logic pin_we_n_o,
  input wire logic [31:0] ext_data_i,
  output logic [31:0] ext_data_o,
  output logic ext_data_oe_o
);
  import absp_pkg::*;

  // ---------------- System clock side ----------------
  absp_ctrl_t ctrl_q;                      // Last command
  logic [ABSP_ADDR_W-1:0] addr_q;          // Word address of the access
  logic [31:0] wdata_q [ABSP_BEATS];       // Write words
  absp_cfg_t cfg_q [ABSP_SPACES];          // Per-space timing
  logic busy_q;                            // Access in flight
  logic done_q;                            // Sticky: an access has finished
  logic req_tgl_q;                         // Flips once per started access
  logic done_seen_q;                       // Last done toggle accepted
  logic done_sync;                         // Done toggle, crossed in
  logic ack_q;
  logic [31:0] rdat_q;
  logic done_tgl_q;                        // Flips once per finished access (memory clock)
  // Only the memory clock writes done_tgl_q; this side sees it through a
  // synchroniser, so a toggle that lands near an edge costs a cycle, never a value.

  // Byte-lane write merge for the bus
  function automatic logic [31:0] absp_merge(input logic [31:0] old_v,
                                             input logic [31:0] new_v,
                                             input logic [3:0] sel);
    logic [31:0] res;
    res = old_v;
    for (int b = 0; b < 4; b++) begin
      if (sel[b]) begin
        res[8*b +: 8] = new_v[8*b +: 8];
      end
    end
    return res;
  endfunction : absp_merge

  // Bus decode
  wire wb_req_w = wb_cyc_i & wb_stb_i & ~ack_q;
  wire wb_wr_w = wb_req_w & wb_we_i & ~busy_q; // Writes ignored while busy
  wire [7:0] adr_w = {wb_adr_i[7:2], 2'b00};
  wire hit_ctrl_w = (adr_w == ABSP_OFS_CTRL);
  wire hit_addr_w = (adr_w == ABSP_OFS_ADDR);
  wire hit_stat_w = (adr_w == ABSP_OFS_STATUS);
  wire hit_data_w = (adr_w[7:4] == ABSP_OFS_DATA0[7:4]);
  wire hit_cfg_w = (adr_w[7:4] == ABSP_OFS_CFG0[7:4]);
  wire [1:0] idx_w = adr_w[3:2];
  wire start_w = wb_wr_w & hit_ctrl_w & wb_sel_i[0];
  wire done_evt_w = (done_sync != done_seen_q);
  // Address register keeps word bits only; the byte offset bits read back as zero
  wire [31:0] addr_mrg_w = absp_merge({10'h000, addr_q, 2'b00}, wb_dat_i, wb_sel_i);

  // Read words from the memory domain, stable whenever busy_q is low
  logic [31:0] mrdata_q [ABSP_BEATS];

  wire [31:0] status_w = {30'h00000000, done_q, busy_q};
  wire [31:0] rd_mux_w = hit_ctrl_w ? ctrl_q :
                         hit_addr_w ? {10'h000, addr_q, 2'b00} :
                         hit_stat_w ? status_w :
                         (hit_data_w & ~busy_q) ? mrdata_q[idx_w] :
                         hit_cfg_w ? (cfg_q[idx_w] & {1'b1, 5'h00, 26'h3FFFFFF}) :
                         32'h00000000;

  // Done toggle back from the memory clock; each change of level is one event
  absp_sync3 #(.W(1)) u_done_sync (
    .clk_i(clk_i),
    .d_i(done_tgl_q),
    .q_o(done_sync)
  );

  // Wishbone answer: ack one cycle after the request is seen
  // The held request is masked while ack is high, so one request gets one answer
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_q <= 1'b0;
      rdat_q <= 32'h00000000;
    end else begin
      ack_q <= wb_req_w;
      rdat_q <= wb_req_w ? rd_mux_w : rdat_q;
    end
  end

  // Command and address registers
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl_q <= ABSP_CTRL_RST;
      addr_q <= '0;
    end else begin
      if (wb_wr_w & hit_ctrl_w) begin
        ctrl_q <= absp_merge(ctrl_q, wb_dat_i, wb_sel_i) & 32'h000000FF;
      end
      if (wb_wr_w & hit_addr_w) begin
        addr_q <= addr_mrg_w[21:2];
      end
    end
  end

  // Per-entry write words and space timings
  for (genvar g = 0; g < ABSP_BEATS; g++) begin : g_regs
    always_ff @(posedge clk_i) begin
      if (rst_i) begin
        wdata_q[g] <= 32'h00000000;
        cfg_q[g] <= ABSP_CFG_RST;
      end else begin
        if (wb_wr_w & hit_data_w & (idx_w == g)) begin
          wdata_q[g] <= absp_merge(wdata_q[g], wb_dat_i, wb_sel_i);
        end
        if (wb_wr_w & hit_cfg_w & (idx_w == g)) begin
          cfg_q[g] <= absp_merge(cfg_q[g], wb_dat_i, wb_sel_i);
        end
      end
    end
  end

  // Request toggle out, done toggle back; a new start wins over done
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      req_tgl_q <= 1'b0;
      done_seen_q <= 1'b0;
      busy_q <= 1'b0;
      done_q <= 1'b0;
    end else begin
      done_seen_q <= done_sync;
      if (start_w) begin
        req_tgl_q <= ~req_tgl_q;
        busy_q <= 1'b1;
        done_q <= 1'b0;
      end else if (done_evt_w) begin
        busy_q <= 1'b0;
        done_q <= 1'b1;
      end
    end
  end

  assign wb_ack_o = ack_q;
  assign wb_dat_o = rdat_q;

  // ---------------- Memory clock side ----------------
  assign memclk_out_o = memclk_in_i;

  logic mem_rst;                           // rst_i crossed into memory clock
  logic req_sync;                          // Request toggle crossed in
  logic ready_sync;                        // Ready level crossed in
  absp_state_t st_q;
  logic [ABSP_CNT_W-1:0] cnt_q;            // Phase period counter
  logic [3:0] beat_q;                      // Burst cycle counter
  logic req_seen_q;
  logic op_write_q;
  logic op_dec_q;
  absp_pins_t pins_q;

  absp_sync3 #(.W(3)) u_mem_sync (
    .clk_i(memclk_in_i),
    .d_i({rst_i, req_tgl_q, async_ready_in_i}),
    .q_o({mem_rst, req_sync, ready_sync})
  );

  // Command fields are quiet while busy, so they are read here directly
  absp_cfg_t cfg_w;
  assign cfg_w = cfg_q[ctrl_q.space];
  wire req_new_w = (req_sync != req_seen_q);
  // Setup is loaded on the edge that also loads op_write_q, so take the command bit
  wire [ABSP_CNT_W-1:0] setup_w = ctrl_q.write ? {2'b00, cfg_w.write_setup_count}
                                               : {2'b00, cfg_w.read_setup_count};
  wire [ABSP_CNT_W-1:0] strobe_w = op_write_q ? cfg_w.write_strobe_count
                                              : cfg_w.read_strobe_count;
  wire [ABSP_CNT_W-1:0] hold_w = op_write_q ? {3'b000, cfg_w.write_hold_count}
                                            : {3'b000, cfg_w.read_hold_count};
  // A zero count still gives one period, so every phase is visible
  wire [ABSP_CNT_W-1:0] strobe_ld_w = (strobe_w == '0) ? 6'h01 : strobe_w;
  wire [ABSP_CNT_W-1:0] hold_ld_w = (hold_w == '0) ? 6'h01 : hold_w;
  wire [ABSP_CNT_W-1:0] setup_ld_w = (setup_w == '0) ? 6'h01 : setup_w;
  wire [3:0] lat_w = 4'(BURST_RD_LAT);
  wire [3:0] burst_end_w = ctrl_q.write ? 4'h3 : (lat_w + 4'h3);
  wire [3:0] rd_word_w = beat_q - lat_w;
  wire rd_take_w = ~op_write_q & (beat_q >= lat_w);
  wire [1:0] next_beat_w = 2'(beat_q + 4'h1);

  // Select group shared by both styles at the start of an access
  absp_pins_t open_w;
  assign open_w = '{~(4'h1 << ctrl_q.space), ~ctrl_q.byte_en, addr_q, 1'b1,
                    1'b1, 1'b1, wdata_q[0], 1'b0};

  // Memory cycle sequencer
  // Every phase is counted in whole memory-clock periods from the pin register,
  // so the pins move only just after a rising edge of the output clock.
  // Ready is looked at only in the last strobe period: an earlier pulse of
  // not-ready is lost, which is why the driver must hold each level a while.
  // Configuration and command are read across the crossing; software must not
  // change them while busy, and the bus refuses such writes anyway.
  always_ff @(posedge memclk_in_i) begin
    if (mem_rst) begin
      st_q <= ABSP_IDLE;
      cnt_q <= '0;
      beat_q <= 4'h0;
      req_seen_q <= req_sync;
      op_write_q <= 1'b0;
      op_dec_q <= 1'b0;
      done_tgl_q <= 1'b0;
      pins_q <= ABSP_PINS_IDLE;
    end else begin
      unique case (st_q)
        ABSP_IDLE: begin
          if (req_new_w) begin
            req_seen_q <= req_sync;
            op_write_q <= ctrl_q.write;
            op_dec_q <= ctrl_q.decrement;
            pins_q <= open_w;
            if (cfg_w.burst_mode) begin
              // First beat: address strobe with the start address
              st_q <= ABSP_BURST;
              beat_q <= 4'h0;
              pins_q.rd_ads_n <= 1'b0;
              pins_q.oe_n <= ctrl_q.write;
              pins_q.we_n <= ~ctrl_q.write;
              pins_q.data_oe <= ctrl_q.write;
            end else begin
              // Selects go valid; output enable joins them on reads
              st_q <= ABSP_SETUP;
              cnt_q <= setup_ld_w;
              pins_q.oe_n <= ctrl_q.write;
            end
          end
        end
        ABSP_SETUP: begin
          // Data goes out after the first setup period
          pins_q.data_oe <= op_write_q;
          if (cnt_q == 6'h01) begin
            st_q <= ABSP_STROBE;
            cnt_q <= strobe_ld_w;
            pins_q.rd_ads_n <= op_write_q;
            pins_q.we_n <= ~op_write_q;
          end else begin
            cnt_q <= cnt_q - 6'h01;
          end
        end
        ABSP_STROBE: begin
          if (cnt_q != 6'h01) begin
            cnt_q <= cnt_q - 6'h01;
          end else if (ready_sync) begin
            // Strobe rises here; unready stretches the last period
            st_q <= ABSP_HOLD;
            cnt_q <= hold_ld_w;
            pins_q.rd_ads_n <= 1'b1;
            pins_q.we_n <= 1'b1;
            if (!op_write_q) begin
              mrdata_q[0] <= ext_data_i;
            end
          end
        end
        ABSP_HOLD: begin
          // Selects and data stay put until the last hold period ends
          if (cnt_q == 6'h01) begin
            st_q <= ABSP_IDLE;
            pins_q <= ABSP_PINS_IDLE;
            done_tgl_q <= ~done_tgl_q;
          end else begin
            cnt_q <= cnt_q - 6'h01;
          end
        end
        ABSP_BURST: begin
          beat_q <= beat_q + 4'h1;
          if (rd_take_w) begin
            mrdata_q[rd_word_w[1:0]] <= ext_data_i;
          end
          if (beat_q == burst_end_w) begin
            st_q <= ABSP_IDLE;
            pins_q <= ABSP_PINS_IDLE;
            done_tgl_q <= ~done_tgl_q;
          end else if (beat_q < 4'h3) begin
            // Memory counts upward on its own; downward needs a new address
            pins_q.rd_ads_n <= ~op_dec_q;
            pins_q.addr <= op_dec_q ? (pins_q.addr - 20'h00001) : pins_q.addr;
            pins_q.data <= wdata_q[next_beat_w];
          end else begin
            // Issue over; reads wait out the pipeline with outputs enabled
            pins_q.rd_ads_n <= 1'b1;
            pins_q.we_n <= 1'b1;
            pins_q.data_oe <= 1'b0;
          end
        end
        default: begin
          st_q <= ABSP_IDLE;
          pins_q <= ABSP_PINS_IDLE;
        end
      endcase
    end
  end

  // Pin outputs straight from the pin register
  // No logic after the flops, so no glitch can reach a strobe pin
  assign chip_space_select_n_o = pins_q.cs_n;
  assign byte_lane_enable_n_o = pins_q.be_n;
  assign ext_address_o = pins_q.addr;
  assign pin_rd_ads_n_o = pins_q.rd_ads_n;
  assign pin_oe_n_o = pins_q.oe_n;
  assign pin_we_n_o = pins_q.we_n;
  assign ext_data_o = pins_q.data;
  assign ext_data_oe_o = pins_q.data_oe;

endmodule : absp_port

// ==== verification/absp_mem_model.sv ====
// Behavioural far-side memory: asynchronous SRAM or burst SRAM with a counter.
`timescale 1ns/1ns
module absp_mem_model (
  input wire logic clk_i,
  input wire logic burst_i,
  input wire logic [3:0] cs_n_i,
  input wire logic [19:0] addr_i,
  input wire logic ads_n_i,
  input wire logic oe_n_i,
  input wire logic we_n_i,
  input wire logic [31:0] d_i,
  output logic [31:0] d_o
);
  logic [31:0] mem [16]; // Small store, low word address bits only
  logic [3:0] cnt_q = 4'h0; // Internal burst counter
  logic [31:0] p1_q; // Read pipeline, stage one
  logic [31:0] p2_q; // Read pipeline, stage two
  logic [31:0] last_q = 32'h00000000; // Last word driven
  wire sel = cs_n_i != 4'hF; // Any space selected
  // A fresh address strobe reloads the counter, otherwise it counts up
  wire [3:0] a = !ads_n_i ? addr_i[3:0] : cnt_q + 4'h1;
  wire [31:0] v = burst_i ? p2_q : mem[addr_i[3:0]]; // Zero access time
  // Released bus shows the inverse of the last word so a stale match cannot pass
  assign d_o = (sel && !oe_n_i) ? v : ~last_q;
  // Async write lands as the write strobe rises
  always @(posedge we_n_i) if (sel && !burst_i) mem[addr_i[3:0]] <= d_i;
  // Burst side runs on the output memory clock, two edges of read latency
  always @(posedge clk_i) begin
    if (!oe_n_i && sel) last_q <= v;
    if (burst_i) begin
      cnt_q <= a;
      if (!we_n_i && sel) mem[a] <= d_i;
      p1_q <= mem[a];
      p2_q <= p1_q;
    end
  end
endmodule : absp_mem_model

// ==== verification/absp_port_chk.sv ====
// Concurrent checks on the port's pins and Wishbone answer.
`timescale 1ns/1ns
module absp_port_chk #(
  parameter int BURST_RD_LAT = 2 // Same as the port
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_ack_o,
  input wire logic memclk_in_i,
  input wire logic memclk_out_o,
  input wire logic [3:0] chip_space_select_n_o,
  input wire logic [19:0] ext_address_o,
  input wire logic pin_rd_ads_n_o,
  input wire logic pin_oe_n_o,
  input wire logic pin_we_n_o,
  input wire logic [31:0] ext_data_o,
  input wire logic ext_data_oe_o
);
  wire sel = chip_space_select_n_o != 4'hF; // Some space selected
  // Reset stretched in the memory clock: the pins settle only once it has crossed
  logic [3:0] mrst_q = 4'hF;
  wire mrst = rst_i | (|mrst_q);
  always @(posedge memclk_in_i) mrst_q <= {mrst_q[2:0], rst_i};
  ack_pulse_a: assert property (@(posedge clk_i) disable iff (rst_i)
    wb_ack_o |=> !wb_ack_o) else $error("ack longer than one cycle");
  ack_wait_a: assert property (@(posedge clk_i) disable iff (rst_i)
    wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o) else $error("ack not next cycle");
  clk_follow_a: assert property (@(posedge clk_i) disable iff (rst_i)
    memclk_out_o == memclk_in_i) else $error("memory clock out differs");
  one_space_a: assert property (@(posedge memclk_in_i) disable iff (mrst)
    $onehot0(~chip_space_select_n_o)) else $error("two spaces selected");
  strobe_sel_a: assert property (@(posedge memclk_in_i) disable iff (mrst)
    !(pin_rd_ads_n_o && pin_we_n_o) |-> sel) else $error("strobe without select");
  wr_data_a: assert property (@(posedge memclk_in_i) disable iff (mrst)
    !pin_we_n_o |-> ext_data_oe_o) else $error("write strobe without data");
  wr_hold_a: assert property (@(posedge memclk_in_i) disable iff (mrst)
    $rose(pin_we_n_o) && sel |-> $stable(ext_address_o) && $stable(ext_data_o)
    && ext_data_oe_o) else $error("write hold broken");
  no_fight_a: assert property (@(posedge memclk_in_i) disable iff (mrst)
    !pin_oe_n_o |-> !ext_data_oe_o) else $error("data driven while enabled");
  async_rd_c: cover property (@(posedge memclk_in_i) disable iff (mrst)
    !pin_oe_n_o && !pin_rd_ads_n_o ##1 !pin_oe_n_o && pin_rd_ads_n_o);
  burst_wr_c: cover property (@(posedge memclk_in_i) disable iff (mrst)
    !pin_rd_ads_n_o && !pin_we_n_o);
  burst_dec_c: cover property (@(posedge memclk_in_i) disable iff (mrst)
    !pin_rd_ads_n_o ##1 !pin_rd_ads_n_o ##1 !pin_rd_ads_n_o);
endmodule : absp_port_chk

bind absp_port absp_port_chk #(.BURST_RD_LAT(BURST_RD_LAT)) i_chk (.clk_i, .rst_i,
  .wb_cyc_i, .wb_stb_i, .wb_ack_o, .memclk_in_i, .memclk_out_o, .chip_space_select_n_o,
  .ext_address_o, .pin_rd_ads_n_o, .pin_oe_n_o, .pin_we_n_o, .ext_data_o, .ext_data_oe_o);

// ==== verification/tb_top.sv ====
// Testbench: register-driven async and burst accesses against a memory model.
`timescale 1ns/1ns
module tb_top;
  import absp_pkg::*;
  logic clk_i = 0, rst_i = 1, mclk = 0, cyc = 0, stb = 0, we = 0, rdy = 1, burst = 0;
  logic [7:0] adr = 8'h00; // Wishbone address
  logic [31:0] dat = 32'h00000000, rdat, mdat, wdat, q; // Bus and memory data
  logic ack, rd_n, oe_n, we_n, doe; // Port answers
  logic [3:0] cs_n, be_n, csv, bev; // Pins and their last seen values
  logic [19:0] ea; // Word address pins
  int err_count = 0, compares = 0;
  int t, f, w, n, d; // Select age, strobe start, strobe length, last age, data start
  absp_port i_dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(dat), .wb_dat_o(q),
    .wb_ack_o(ack), .memclk_in_i(mclk), .memclk_out_o(), .async_ready_in_i(rdy),
    .chip_space_select_n_o(cs_n), .byte_lane_enable_n_o(be_n), .ext_address_o(ea),
    .pin_rd_ads_n_o(rd_n), .pin_oe_n_o(oe_n), .pin_we_n_o(we_n), .ext_data_i(mdat),
    .ext_data_o(wdat), .ext_data_oe_o(doe));
  absp_mem_model i_mem (.clk_i(mclk), .burst_i(burst), .cs_n_i(cs_n), .addr_i(ea),
    .ads_n_i(rd_n), .oe_n_i(oe_n), .we_n_i(we_n), .d_i(wdat), .d_o(mdat));
  initial begin
    forever #20 clk_i = ~clk_i;
  end
  // Link clock, phase offset keeps its edges away from the system clock edges
  initial begin
    #7;
    forever #32 mclk = ~mclk;
  end
  // Phase meter on the falling edge, where the pins have settled
  always @(negedge mclk) begin
    if (cs_n != 4'hF) begin
      t++;
      csv = cs_n;
      bev = be_n;
      if (!(rd_n && we_n)) begin
        w++;
        if (f == 0) f = t;
      end
      if (doe && d == 0) d = t;
      n = t;
    end
  end
  task conclude();
    if (err_count == 0 && compares > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : conclude
  task chk(input string nm, input logic [31:0] s, input logic [31:0] e);
    compares++;
    if (s !== e) begin
      err_count++;
      $display("ERROR %s expected %h seen %h", nm, e, s);
    end
  endtask : chk
  // Classic single cycle, held until ack is sampled high
  task wb(input logic w_i, input logic [7:0] a, input logic [31:0] v);
    int k;
    @(posedge clk_i);
    cyc <= 1;
    stb <= 1;
    we <= w_i;
    adr <= a;
    dat <= v;
    k = 0;
    do begin
      @(posedge clk_i);
      k++;
    end while (ack !== 1'b1 && k < 50);
    rdat = q;
    cyc <= 0;
    stb <= 0;
    if (k >= 50) chk("ack", 0, 1);
  endtask : wb
  // Start one access and poll until done
  task go(input absp_ctrl_t c_i);
    t = 0;
    f = 0;
    w = 0;
    n = 0;
    d = 0;
    wb(1, ABSP_OFS_CTRL, c_i);
    repeat (300) begin
      wb(0, ABSP_OFS_STATUS, 0);
      if (rdat[ABSP_ST_DONE] === 1'b1) break;
    end
    chk("done", rdat[ABSP_ST_DONE], 1);
  endtask : go
  initial begin
    int rs[2] = '{2, 1}; // Setup counts; strobes sized for the zero-delay model
    int st[2] = '{3, 1};
    int rh[2] = '{1, 2};
    absp_cfg_t cfg;
    repeat (6) @(posedge clk_i);
    rst_i <= 0;
    repeat (10) @(posedge clk_i);
    wb(0, ABSP_OFS_CFG0 + 8'h04, 0);
    chk("cfg1 reset", rdat, ABSP_CFG_RST);
    wb(1, ABSP_OFS_CFG0 + 8'h04, 32'hFFFFFFFF);
    wb(0, ABSP_OFS_CFG0 + 8'h04, 0);
    chk("cfg1 fields", rdat, 32'h83FFFFFF);
    wb(0, 8'hF0, 0);
    chk("unmapped", rdat, 0);
    for (int i = 0; i < 2; i++) begin
      cfg = '{1'b0, 5'h00, 3'(rh[i]), 6'(st[i]), 4'(rs[i]), 3'(rh[i]), 6'(st[i]), 4'(rs[i])};
      wb(1, ABSP_OFS_CFG0 + 8'(4 * i), cfg);
      wb(1, ABSP_OFS_ADDR, 32'(4 * (i + 1)));
      wb(1, ABSP_OFS_DATA0, 32'hA5C30000 + i);
      go('{24'h000000, 4'h5, 1'b0, 1'b1, 2'(i)});
      chk("wr setup", 32'(f - 1), 32'(rs[i]));
      chk("wr strobe", 32'(w), 32'(st[i]));
      chk("wr hold", 32'(n - f + 1 - w), 32'(rh[i]));
      chk("data lead", 32'(f - d), 32'(rs[i] - 1));
      chk("space", csv, 4'hF ^ (4'h1 << i));
      chk("lanes", bev, 4'hA);
      wb(1, ABSP_OFS_DATA0, 0);
      go('{24'h000000, 4'hF, 1'b0, 1'b0, 2'(i)});
      chk("rd setup", 32'(f - 1), 32'(rs[i]));
      chk("rd strobe", 32'(w), 32'(st[i]));
      chk("rd hold", 32'(n - f + 1 - w), 32'(rh[i]));
      wb(0, ABSP_OFS_DATA0, 0);
      chk("rd data", rdat, 32'hA5C30000 + i);
    end
    // Ready held low for many periods, well over two
    rdy <= 0;
    fork
      go('{24'h000000, 4'hF, 1'b0, 1'b0, 2'h0});
      begin
        repeat (20) @(posedge mclk);
        @(posedge clk_i);
        rdy <= 1;
      end
    join
    chk("ready stretch", 32'(w > 8), 1);
    burst <= 1;
    wb(1, ABSP_OFS_CFG0 + 8'h0C, 32'h80000000);
    wb(1, ABSP_OFS_ADDR, 32'h00000010);
    for (int k = 0; k < 4; k++) wb(1, ABSP_OFS_DATA0 + 8'(4 * k), 32'h11110000 + k);
    go('{24'h000000, 4'hF, 1'b0, 1'b1, 2'h3});
    chk("burst wr beats", 32'(w), 4);
    for (int k = 0; k < 4; k++) wb(1, ABSP_OFS_DATA0 + 8'(4 * k), 0);
    go('{24'h000000, 4'hF, 1'b0, 1'b0, 2'h3});
    chk("inc strobes", 32'(w), 1);
    for (int k = 0; k < 4; k++) begin
      wb(0, ABSP_OFS_DATA0 + 8'(4 * k), 0);
      chk("inc word", rdat, 32'h11110000 + k);
    end
    wb(1, ABSP_OFS_ADDR, 32'h0000001C);
    go('{24'h000000, 4'hF, 1'b1, 1'b0, 2'h3});
    chk("dec strobes", 32'(w), 4);
    for (int k = 0; k < 4; k++) begin
      wb(0, ABSP_OFS_DATA0 + 8'(4 * k), 0);
      chk("dec word", rdat, 32'h11110003 - k);
    end
    conclude();
  end
  // Watchdog well beyond the expected run length
  initial begin
    #2000000;
    err_count++;
    conclude();
  end
endmodule : tb_top
